// file: omc_pkg.sv
// constants of the operation mode controller
package omc_pkg;
  // channel and pin counts
  localparam int NUM_CH = 8;
  localparam int NUM_IN = 2;
  // mode status field codes
  localparam logic [1:0] MODE_SLEEP_CODE  = 2'h3;
  localparam logic [1:0] MODE_LIMP_CODE   = 2'h1;
  localparam logic [1:0] MODE_ACTIVE_CODE = 2'h2;
  localparam logic [1:0] MODE_IDLE_CODE   = 2'h0;
  // register reset values
  localparam logic [7:0] CHAN_ON_RST = 8'h00;
  localparam logic       KEEP_ACT_RST = 1'b0;
  localparam logic       PWM_EN_RST   = 1'b0;
  localparam logic [7:0] MAP0_RST    = 8'h04;
  localparam logic [7:0] MAP1_RST    = 8'h08;
  // channels that may run in limp home
  localparam logic [7:0] LIMP_CH_MASK = 8'h0C;
  // wake latency from idle or sleep into a driving mode
  localparam int WAKE_TIME_NS = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_CYC = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // synchronised pin vector layout
  localparam int SYNC_W = 9;
  localparam int S_STBY = 0;
  localparam int S_IN0  = 1;
  localparam int S_IN1  = 2;
  localparam int S_VSP  = 3;
  localparam int S_VDDP = 4;
  localparam int S_VSOP = 5;
  localparam int S_VDDL = 6;
  localparam int S_VSUV = 7;
  localparam int S_VDUV = 8;
endpackage

// file: omc_sync.sv
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module omc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// file: omc_operation_mode_controller.sv
// operation mode state machine of an eight channel serial power switch
// Functional notes
// (R1) mode chosen from pins, channel, keep and pwm bits
// (R2) switch-on request wakes to active or limp home
// (R3) sleep: outputs off, registers held reset
// (R4) idle: channels off, no diagnosis
// (R5) idle with logic supply: registers and serial work
// (R6) idle keeps channel error bits
// (R7) standby high plus input or channel bit: active
// (R8) keep bit clear: idle when no request
// (R9) keep bit set: stay active
// (R10) logic undervoltage, inputs low: go idle
// (R11) input high wakes active even unmapped
// (R12) standby low plus input: limp home, channel on
// (R13) limp home: reads answered, writes ignored
// (R14) limp home forces both supply flags high
// (R15) limp home mode field reads 01
// (R16) limp home: first command sets transmission error
// (R17) limp home holds open-load flags low
// (R18) limp home: others at default, errors normal
// (R19) limp home drives only channels two, three
// (R20) host avoids commands during limp transitions
// (R21) wake latency added before channel turn-on
// (R22) power-on needs supply, pin high, threshold
// (R23) soft reset keeps errors, clears supply flags
`timescale 1ns/1ps
module omc_operation_mode_controller #(
  parameter int NCH = omc_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // device pins and supply comparators, asynchronous
  input  wire logic           standby_sel_pin,
  input  wire logic [1:0]     direct_input_pins,
  input  wire logic           vs_present,
  input  wire logic           vdd_present,
  input  wire logic           vs_above_op,
  input  wire logic           vdd_above_lop,
  input  wire logic           vs_undervoltage,
  input  wire logic           vdd_undervoltage,
  // register write port from the serial front end
  input  wire logic           wr_valid,
  input  wire logic [NCH-1:0] wr_channel_on,
  input  wire logic           wr_keep_active,
  input  wire logic           wr_pwm_gen0,
  input  wire logic           wr_pwm_gen1,
  input  wire logic [NCH-1:0] wr_input0_map,
  input  wire logic [NCH-1:0] wr_input1_map,
  input  wire logic           wr_soft_reset,
  // serial command events
  input  wire logic           spi_cmd_strobe,
  input  wire logic           spi_frame_error,
  input  wire logic           diag_readout,
  // diagnosis events from the output stages
  input  wire logic [NCH-1:0] channel_fault,
  input  wire logic           open_load_on_event,
  input  wire logic           open_load_off_event,
  // channel drive and mode status
  output logic [NCH-1:0]      channel_drive,
  output logic [1:0]          mode_status,
  output logic                power_on,
  output logic                spi_available,
  output logic                spi_writable,
  // register read-back
  output logic [NCH-1:0]      channel_on_bits,
  output logic                keep_active_bit,
  output logic                pwm_gen0_enable,
  output logic                pwm_gen1_enable,
  output logic [NCH-1:0]      input0_channel_map,
  output logic [NCH-1:0]      input1_channel_map,
  output logic [NCH-1:0]      channel_error_bits,
  output logic [NCH-1:0]      output_monitor_bits,
  output logic                supply_undervoltage_flag,
  output logic                logic_supply_low_flag,
  output logic                transmission_error_flag,
  output logic                open_load_on_flag,
  output logic                open_load_off_flag
);
  typedef enum logic [2:0] {ST_SLEEP, ST_IDLE, ST_WAKE, ST_ACTIVE, ST_LIMP} omc_state_t;

  localparam int WCW = $clog2(omc_pkg::WAKE_CYC + 1);
  localparam logic [WCW-1:0] WAKE_LAST = WCW'(omc_pkg::WAKE_CYC - 1);

  logic [omc_pkg::SYNC_W-1:0] pins_s;
  omc_state_t                 state_reg;
  omc_state_t                 state_next;
  logic [WCW-1:0]             wake_cnt_reg;
  logic                       ter_pending_reg;
  logic                       stby_s;
  logic                       any_in_s;
  logic                       pwr_ok;
  logic                       vs_uv_s;
  logic                       vdd_uv_s;
  logic                       regs_clear;
  logic                       wr_ok;
  logic [NCH-1:0]             mapped_in;
  logic [NCH-1:0]             drive_next;

  // every pin passes two flip-flops before use
  omc_sync #(
    .WIDTH (omc_pkg::SYNC_W)
  ) u_pin_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({vdd_undervoltage, vs_undervoltage, vdd_above_lop, vs_above_op,
                vdd_present, vs_present, direct_input_pins, standby_sel_pin}),
    .sync_out (pins_s)
  );

  // decoded pin levels
  assign stby_s   = pins_s[omc_pkg::S_STBY];
  assign any_in_s = pins_s[omc_pkg::S_IN0] | pins_s[omc_pkg::S_IN1];
  assign vs_uv_s  = pins_s[omc_pkg::S_VSUV];
  assign vdd_uv_s = pins_s[omc_pkg::S_VDUV];
  // supply applied, a pin high, and one supply above its threshold
  assign pwr_ok = (pins_s[omc_pkg::S_VSP] | pins_s[omc_pkg::S_VDDP])
                & (any_in_s | stby_s)
                & (pins_s[omc_pkg::S_VSOP] | pins_s[omc_pkg::S_VDDL]); // [R22]

  // mode transitions
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SLEEP, ST_IDLE:
      begin
        if (!pwr_ok || !stby_s && !any_in_s)
          state_next = ST_SLEEP; // [R3]
        else if (!stby_s || any_in_s || (|channel_on_bits))
          state_next = ST_WAKE; // [R2] [R21]
        else
          state_next = ST_IDLE;
      end
      ST_WAKE:
      begin
        if (!pwr_ok || !stby_s && !any_in_s)
          state_next = ST_SLEEP;
        else if (wake_cnt_reg == WAKE_LAST)
          state_next = stby_s ? ST_ACTIVE : ST_LIMP; // [R2] [R7] [R11] [R12]
      end
      ST_ACTIVE:
      begin
        if (!pwr_ok || !stby_s && !any_in_s)
          state_next = ST_SLEEP;
        else if (!stby_s)
          state_next = ST_LIMP; // [R12]
        else if (vdd_uv_s && !any_in_s)
          state_next = ST_IDLE; // [R10]
        else if (!keep_active_bit && !any_in_s && !(|channel_on_bits)
                 && !pwm_gen0_enable && !pwm_gen1_enable)
          state_next = ST_IDLE; // [R1] [R8] [R9]
      end
      ST_LIMP:
      begin
        if (!pwr_ok || !stby_s && !any_in_s)
          state_next = ST_SLEEP;
        else if (stby_s)
          state_next = ST_ACTIVE; // [R7]
      end
    endcase
  end

  // state register and wake latency counter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg    <= ST_SLEEP;
      wake_cnt_reg <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      wake_cnt_reg <= (state_reg == ST_WAKE) ? wake_cnt_reg + WCW'(1) : '0; // [R21]
    end
  end

  // registers reset in sleep, in limp home, without logic supply, and on soft reset
  assign wr_ok = wr_valid && !vdd_uv_s
              && (state_reg == ST_IDLE || state_reg == ST_ACTIVE); // [R5] [R13]
  assign regs_clear = state_reg == ST_SLEEP || state_reg == ST_LIMP || vdd_uv_s
                   || (wr_ok && wr_soft_reset); // [R3] [R18] [R23]

  // programmable control registers
  always_ff @(posedge clk)
  begin
    if (rst || regs_clear)
    begin
      channel_on_bits    <= omc_pkg::CHAN_ON_RST;
      keep_active_bit    <= omc_pkg::KEEP_ACT_RST;
      pwm_gen0_enable    <= omc_pkg::PWM_EN_RST;
      pwm_gen1_enable    <= omc_pkg::PWM_EN_RST;
      input0_channel_map <= omc_pkg::MAP0_RST;
      input1_channel_map <= omc_pkg::MAP1_RST;
    end
    else if (wr_ok)
    begin
      channel_on_bits    <= wr_channel_on;
      keep_active_bit    <= wr_keep_active;
      pwm_gen0_enable    <= wr_pwm_gen0;
      pwm_gen1_enable    <= wr_pwm_gen1;
      input0_channel_map <= wr_input0_map;
      input1_channel_map <= wr_input1_map;
    end
  end

  // per-channel error bits, sticky, set wins, survive idle and soft reset
  always_ff @(posedge clk)
  begin
    if (rst || state_reg == ST_SLEEP || vdd_uv_s)
      channel_error_bits <= '0;
    else if (state_reg == ST_ACTIVE || state_reg == ST_LIMP)
      channel_error_bits <= (diag_readout ? '0 : channel_error_bits) | channel_fault; // [R18]
    else
      channel_error_bits <= channel_error_bits; // [R4] [R6]
  end

  // supply flags: sticky, cleared by readout once supply recovered, set wins
  always_ff @(posedge clk)
  begin
    if (rst || state_reg == ST_SLEEP)
    begin
      supply_undervoltage_flag <= 1'b0;
      logic_supply_low_flag    <= 1'b0;
    end
    else if (state_next == ST_LIMP)
    begin
      supply_undervoltage_flag <= 1'b1; // [R14]
      logic_supply_low_flag    <= 1'b1; // [R14]
    end
    else if (wr_ok && wr_soft_reset)
    begin
      supply_undervoltage_flag <= vs_uv_s; // [R23]
      logic_supply_low_flag    <= !pins_s[omc_pkg::S_VDDL]; // [R23]
    end
    else
    begin
      supply_undervoltage_flag <= vs_uv_s | (supply_undervoltage_flag & !diag_readout);
      logic_supply_low_flag    <= !pins_s[omc_pkg::S_VDDL]
                                | (logic_supply_low_flag & !diag_readout);
    end
  end

  // transmission error, armed on limp home entry, set on next command
  always_ff @(posedge clk)
  begin
    if (rst || state_reg == ST_SLEEP)
    begin
      ter_pending_reg         <= 1'b0;
      transmission_error_flag <= 1'b0;
    end
    else
    begin
      if (state_next == ST_LIMP && state_reg != ST_LIMP)
        ter_pending_reg <= 1'b1;
      else if (spi_cmd_strobe)
        ter_pending_reg <= 1'b0;
      if (spi_cmd_strobe && (ter_pending_reg || spi_frame_error))
        transmission_error_flag <= 1'b1; // [R16]
      else if (spi_cmd_strobe)
        transmission_error_flag <= 1'b0;
    end
  end

  // open-load flags, only while diagnosing in active mode
  always_ff @(posedge clk)
  begin
    if (rst || state_reg != ST_ACTIVE)
    begin
      open_load_on_flag  <= 1'b0; // [R17] [R4]
      open_load_off_flag <= 1'b0; // [R17]
    end
    else
    begin
      open_load_on_flag  <= open_load_on_event | (open_load_on_flag & !diag_readout);
      open_load_off_flag <= open_load_off_event | (open_load_off_flag & !diag_readout);
    end
  end

  // channel drive from inputs through the maps and from the channel bits
  assign mapped_in = (pins_s[omc_pkg::S_IN0] ? input0_channel_map : '0)
                   | (pins_s[omc_pkg::S_IN1] ? input1_channel_map : '0);
  always_comb
  begin
    drive_next = '0; // [R3] [R4] [R21]
    if (state_reg == ST_ACTIVE && !vs_uv_s)
      drive_next = vdd_uv_s ? mapped_in : (mapped_in | channel_on_bits);
    else if (state_reg == ST_LIMP && !vs_uv_s)
      drive_next = mapped_in & omc_pkg::LIMP_CH_MASK; // [R12] [R19]
  end

  // registered outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      channel_drive       <= '0;
      output_monitor_bits <= '0;
      mode_status         <= omc_pkg::MODE_SLEEP_CODE;
      power_on            <= 1'b0;
      spi_available       <= 1'b0;
      spi_writable        <= 1'b0;
    end
    else
    begin
      channel_drive       <= drive_next;
      output_monitor_bits <= drive_next;
      power_on            <= pwr_ok; // [R22]
      spi_available       <= state_reg != ST_SLEEP && !vdd_uv_s; // [R5] [R13]
      spi_writable        <= (state_reg == ST_IDLE || state_reg == ST_ACTIVE) && !vdd_uv_s;
      unique case (state_reg)
        ST_SLEEP:          mode_status <= omc_pkg::MODE_SLEEP_CODE;
        ST_IDLE, ST_WAKE:  mode_status <= omc_pkg::MODE_IDLE_CODE;
        ST_ACTIVE:         mode_status <= omc_pkg::MODE_ACTIVE_CODE;
        ST_LIMP:           mode_status <= omc_pkg::MODE_LIMP_CODE; // [R15]
      endcase
    end
  end

  // checks on the mode machine and its side effects
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wake_to_active;
    state_reg == ST_WAKE ##[1:40] state_reg == ST_ACTIVE;
  endsequence

  property p_sleep_off;
    state_reg == ST_SLEEP |=> channel_drive == '0 && channel_on_bits == omc_pkg::CHAN_ON_RST;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep drives a channel"); // [R3]

  property p_idle_off;
    state_reg == ST_IDLE |=> channel_drive == '0 && !open_load_on_flag;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle drives or diagnoses"); // [R4]

  property p_idle_err_kept;
    state_reg == ST_IDLE && !vdd_uv_s |=> channel_error_bits == $past(channel_error_bits);
  endproperty
  a_idle_err_kept: assert property (p_idle_err_kept) else $error("idle lost error bits"); // [R6]

  property p_wake;
    state_reg == ST_IDLE && pwr_ok && stby_s && any_in_s |=> s_wake_to_active;
  endproperty
  a_wake: assert property (p_wake) else $error("input did not wake active"); // [R7]

  property p_back_idle;
    state_reg == ST_ACTIVE && pwr_ok && stby_s && !any_in_s && !keep_active_bit
    && channel_on_bits == '0 && !pwm_gen0_enable && !pwm_gen1_enable
    |=> state_reg == ST_IDLE;
  endproperty
  a_back_idle: assert property (p_back_idle) else $error("active did not return idle"); // [R8]

  property p_keep;
    state_reg == ST_ACTIVE && keep_active_bit && stby_s && pwr_ok && !vdd_uv_s
    |=> state_reg == ST_ACTIVE;
  endproperty
  a_keep: assert property (p_keep) else $error("keep bit did not hold active"); // [R9]

  property p_limp_ro;
    state_reg == ST_LIMP |=> keep_active_bit == omc_pkg::KEEP_ACT_RST
                          && input0_channel_map == omc_pkg::MAP0_RST;
  endproperty
  a_limp_ro: assert property (p_limp_ro) else $error("limp home register changed"); // [R13]

  property p_limp_status;
    mode_status == omc_pkg::MODE_LIMP_CODE |-> supply_undervoltage_flag
      && logic_supply_low_flag && !open_load_on_flag && !open_load_off_flag
      && (channel_drive & ~omc_pkg::LIMP_CH_MASK) == '0;
  endproperty
  a_limp_status: assert property (p_limp_status) else $error("limp home status wrong"); // [R14]

  property p_limp_ter;
    state_next == ST_LIMP && state_reg != ST_LIMP |=> ter_pending_reg;
  endproperty
  a_limp_ter: assert property (p_limp_ter) else $error("limp entry not armed"); // [R16]

  property p_soft_reset;
    wr_ok && wr_soft_reset && !channel_fault[0] |=> keep_active_bit == omc_pkg::KEEP_ACT_RST
      && channel_error_bits[0] == $past(channel_error_bits[0]);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong"); // [R23]

  property p_limp_first_cmd;
    ter_pending_reg && spi_cmd_strobe && state_reg == ST_LIMP |=> transmission_error_flag;
  endproperty
  a_limp_first_cmd: assert property (p_limp_first_cmd) else $error("no error flag"); // [R16]
endmodule

// file: omc_host_model.sv
// host side model that issues serial commands to the mode controller
`timescale 1ns/1ps
module omc_host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // command request from the bench
  input  wire logic       cmd_req,
  input  wire logic       cmd_bad,
  // device side
  input  wire logic [1:0] mode_status,
  output logic            spi_cmd_strobe,
  output logic            spi_frame_error
);
  logic [1:0] last_mode;
  logic [2:0] calm_cnt;
  // counts cycles for which the reported mode has held still
  always_ff @(posedge clk)
  begin
    last_mode <= mode_status;
    if (rst || mode_status != last_mode)
      calm_cnt <= 3'h0;
    else if (calm_cnt != 3'h7)
      calm_cnt <= calm_cnt + 3'h1;
  end
  // one command per request, held off while the mode is changing
  always_ff @(posedge clk)
  begin
    spi_cmd_strobe  <= 1'b0;
    spi_frame_error <= 1'b0;
    if (!rst && cmd_req && !spi_cmd_strobe && calm_cnt == 3'h7)
    begin
      spi_cmd_strobe  <= 1'b1;
      spi_frame_error <= cmd_bad;
    end
  end
endmodule

// file: omc_operation_mode_controller_bench.sv
// self-checking bench of the operation mode controller
`timescale 1ns/1ps
module omc_operation_mode_controller_bench;
  logic       clk, rst, stby, vdd_uv, wr_valid, wr_keep, wr_sr, diag, ol_on, ol_off;
  logic       cmd_req, cmd_bad, spi_cmd_strobe, spi_frame_error;
  logic [1:0] din, wr_pwm, mode;
  logic [7:0] wr_ch, wr_m0, wr_m1, fault, drive, ch_bits, map0, map1, errs, mon;
  logic       pwr, spi_av, spi_wr, keep, pwm0, pwm1, uv_f, lop_f, ter_f, open_load_on_flag_f, open_load_off_flag_f;
  int         err_count, tests_run;

  omc_operation_mode_controller u_omc_operation_mode_controller (
    .clk(clk), .rst(rst), .standby_sel_pin(stby), .direct_input_pins(din),
    .vs_present(1'b1), .vdd_present(1'b1), .vs_above_op(1'b1), .vdd_above_lop(1'b1),
    .vs_undervoltage(1'b0), .vdd_undervoltage(vdd_uv),
    .wr_valid(wr_valid), .wr_channel_on(wr_ch), .wr_keep_active(wr_keep),
    .wr_pwm_gen0(wr_pwm[0]), .wr_pwm_gen1(wr_pwm[1]), .wr_input0_map(wr_m0),
    .wr_input1_map(wr_m1), .wr_soft_reset(wr_sr), .spi_cmd_strobe(spi_cmd_strobe),
    .spi_frame_error(spi_frame_error), .diag_readout(diag), .channel_fault(fault),
    .open_load_on_event(ol_on), .open_load_off_event(ol_off), .channel_drive(drive),
    .mode_status(mode), .power_on(pwr), .spi_available(spi_av), .spi_writable(spi_wr),
    .channel_on_bits(ch_bits), .keep_active_bit(keep), .pwm_gen0_enable(pwm0),
    .pwm_gen1_enable(pwm1), .input0_channel_map(map0), .input1_channel_map(map1),
    .channel_error_bits(errs), .output_monitor_bits(mon),
    .supply_undervoltage_flag(uv_f), .logic_supply_low_flag(lop_f),
    .transmission_error_flag(ter_f), .open_load_on_flag(open_load_on_flag_f),
    .open_load_off_flag(open_load_off_flag_f)
  );

  omc_host_model u_omc_host_model (
    .clk(clk), .rst(rst), .cmd_req(cmd_req), .cmd_bad(cmd_bad), .mode_status(mode),
    .spi_cmd_strobe(spi_cmd_strobe), .spi_frame_error(spi_frame_error)
  );

  // clock at 100 MHz
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // prints the verdict and ends the run
  task automatic close_out();
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // compares a seen value with the expected one
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one register write; returns when the read-back has settled
  task automatic wr(input logic [7:0] ch, input logic kp, input logic [1:0] pw,
                    input logic [7:0] m0, input logic [7:0] m1, input logic sr);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_ch    <= ch;
    wr_keep  <= kp;
    wr_pwm   <= pw;
    wr_m0    <= m0;
    wr_m1    <= m1;
    wr_sr    <= sr;
    @(posedge clk);
    wr_valid <= 1'b0;
    wr_sr    <= 1'b0;
    #1;
  endtask

  // sets standby-select and direct input levels
  task automatic pin(input logic sb, input logic [1:0] ins);
    @(posedge clk);
    stby <= sb;
    din  <= ins;
  endtask

  // waits a bounded time for a mode code, then compares it
  task automatic wait_mode(input logic [1:0] exp);
    for (int i = 0; i < 60 && mode !== exp; i++)
    begin
      @(posedge clk);
      #1;
    end
    check(mode, exp);
  endtask

  // one serial command through the host model, then the error flag
  task automatic cmd(input logic bad, input logic exp);
    int i;
    @(posedge clk);
    cmd_req <= 1'b1;
    cmd_bad <= bad;
    for (i = 0; i < 40 && spi_cmd_strobe !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    cmd_req <= 1'b0;
    #1;
    check(ter_f, exp);
  endtask

  // pulses a one-cycle event on the diagnosis inputs
  task automatic pulse(input logic [7:0] f, input logic on, input logic off, input logic rd);
    @(posedge clk);
    fault  <= f;
    ol_on  <= on;
    ol_off <= off;
    diag   <= rd;
    @(posedge clk);
    fault  <= 8'h00;
    {ol_on, ol_off, diag} <= 3'h0;
    tick(2);
    #1;
  endtask

  // watchdog against a hang
  initial
  begin
    tick(20000);
    err_count++;
    close_out();
  end

  // main sequence
  initial
  begin
    err_count = 0;
    tests_run = 0;
    {rst, stby, vdd_uv, wr_valid, wr_keep, wr_sr, diag, ol_on, ol_off} = '0;
    {cmd_req, cmd_bad, din, wr_pwm, wr_ch, wr_m0, wr_m1, fault} = '0;
    rst = 1'b1;
    tick(6);
    rst <= 1'b0;
    tick(2);
    #1;
    check(mode, omc_pkg::MODE_SLEEP_CODE);
    check(drive, 8'h00);
    check({map1, map0}, {omc_pkg::MAP1_RST, omc_pkg::MAP0_RST});
    check(spi_wr, 1'b0);
    // standby high, nothing requested: idle
    pin(1'b1, 2'h0);
    wait_mode(omc_pkg::MODE_IDLE_CODE);
    check(pwr, 1'b1);
    check({spi_av, spi_wr}, 2'h3);
    check(drive, 8'h00);
    // channel bit wakes active after the wake latency
    wr(8'h01, 1'b0, 2'h0, 8'h04, 8'h08, 1'b0);
    check(ch_bits, 8'h01);
    tick(4);
    #1;
    check({mode, drive}, {omc_pkg::MODE_IDLE_CODE, 8'h00});
    wait_mode(omc_pkg::MODE_ACTIVE_CODE);
    check(drive, 8'h01);
    pulse(8'h01, 1'b0, 1'b0, 1'b0);
    check(errs, 8'h01);
    // pwm enables and keep bit hold active mode
    wr(8'h00, 1'b0, 2'h1, 8'h04, 8'h08, 1'b0);
    tick(30);
    check({pwm1, pwm0, mode}, {2'h1, omc_pkg::MODE_ACTIVE_CODE});
    wr(8'h00, 1'b0, 2'h2, 8'h04, 8'h08, 1'b0);
    tick(30);
    check({pwm1, pwm0, mode}, {2'h2, omc_pkg::MODE_ACTIVE_CODE});
    wr(8'h00, 1'b1, 2'h0, 8'h04, 8'h08, 1'b0);
    tick(30);
    check({keep, mode}, {1'b1, omc_pkg::MODE_ACTIVE_CODE});
    wr(8'h00, 1'b0, 2'h0, 8'h04, 8'h08, 1'b0);
    wait_mode(omc_pkg::MODE_IDLE_CODE);
    pulse(8'h00, 1'b0, 1'b0, 1'b1);
    check(errs, 8'h01);
    check(drive, 8'h00);
    // unmapped input still wakes active
    wr(8'h00, 1'b0, 2'h0, 8'h00, 8'h00, 1'b0);
    pin(1'b1, 2'h1);
    wait_mode(omc_pkg::MODE_ACTIVE_CODE);
    check(drive, 8'h00);
    wr(8'h01, 1'b0, 2'h0, 8'h00, 8'h00, 1'b0);
    pin(1'b1, 2'h0);
    tick(30);
    @(posedge clk);
    vdd_uv <= 1'b1;
    wait_mode(omc_pkg::MODE_IDLE_CODE);
    @(posedge clk);
    vdd_uv <= 1'b0;
    tick(6);
    // soft reset keeps error bits, clears the rest
    wr(8'h01, 1'b0, 2'h0, 8'h04, 8'h08, 1'b0);
    wait_mode(omc_pkg::MODE_ACTIVE_CODE);
    // vdd undervoltage cleared the error bits, so set one again first
    pulse(8'h01, 1'b0, 1'b0, 1'b0);
    wr(8'h00, 1'b0, 2'h0, 8'h00, 8'h00, 1'b1);
    check({errs, ch_bits}, {8'h01, 8'h00});
    check({uv_f, lop_f}, 2'h0);
    wait_mode(omc_pkg::MODE_IDLE_CODE);
    // limp home: read only, defaults, limited channels
    wr(8'h00, 1'b0, 2'h0, 8'h01, 8'h02, 1'b0);
    pin(1'b0, 2'h1);
    wait_mode(omc_pkg::MODE_LIMP_CODE);
    tick(1);
    #1;
    check(drive, omc_pkg::MAP0_RST);
    check({map1, map0}, {omc_pkg::MAP1_RST, omc_pkg::MAP0_RST});
    check({uv_f, lop_f}, 2'h3);
    pulse(8'h00, 1'b1, 1'b1, 1'b0);
    check({open_load_on_flag_f, open_load_off_flag_f}, 2'h0);
    wr(8'hFF, 1'b1, 2'h3, 8'hFF, 8'hFF, 1'b0);
    check({ch_bits, keep, pwm0, spi_wr}, {8'h00, 3'h0});
    cmd(1'b0, 1'b1);
    cmd(1'b0, 1'b0);
    cmd(1'b1, 1'b1);
    pin(1'b0, 2'h3);
    tick(5);
    #1;
    check(drive, omc_pkg::LIMP_CH_MASK);
    check(mon, omc_pkg::LIMP_CH_MASK);
    // standby high leaves limp home; a soft reset then clears both supply flags
    pin(1'b1, 2'h3);
    wait_mode(omc_pkg::MODE_ACTIVE_CODE);
    wr(8'h00, 1'b0, 2'h0, 8'h04, 8'h08, 1'b1);
    check({uv_f, lop_f}, 2'h0);
    pin(1'b0, 2'h0);
    wait_mode(omc_pkg::MODE_SLEEP_CODE);
    tick(1);
    #1;
    check({drive, ch_bits}, 16'h0000);
    close_out();
  end
endmodule
